// ---- bench/mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import l1_pkg::*;
(
    // clock
    input  wire logic  pclk,
    // fill port
    input  wire areq_t fill_req,
    output beat_t      fill_beat
);
    logic [31:0] a;
    logic [31:0] w;
    logic        slow = 1'b0;
    initial fill_beat = '0;
    always @(posedge pclk)
    begin
        if (fill_req.valid === 1'b1)
        begin
            a = fill_req.addr;
            // every other fill stalls, so refusal is exercised
            slow = ~slow;
            for (int k = 0; k < 4; k++)
            begin
                if (slow)
                    @(posedge pclk);
                w = {a[31:5], a[4:3] + k[1:0], 3'h0};
                fill_beat <= '{1'b1, {w | 32'h4, w}};
                @(posedge pclk);
                if (slow || k == 3)
                    fill_beat <= '{1'b0, ~fill_beat.data};
            end
        end
    end
endmodule // mem_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import l1_pkg::*;
;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic         pready, pslverr, snoop_hit, snoop_retry, err;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, r, fa;
    logic [1:0]   h;
    ls_req_t      ls_req = '0;
    areq_t        if_req = '0, snoop = '0, fill_req;
    rsp_t         ls_rsp, if_rsp;
    beat_t        fill_beat;
    bus_wr_t      mem_wr;
    bus_wr_t      wq[$];
    int           mismatches, checked, nbeat, n, i;
    split_l1_cache dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .ls_req, .ls_rsp, .if_req, .if_rsp, .snoop, .snoop_hit,
        .snoop_retry, .fill_req, .fill_beat, .mem_wr);
    mem_model mem_u (.pclk, .fill_req, .fill_beat);
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (mem_wr.valid === 1'b1)
            wq.push_back(mem_wr);
        if (fill_beat.valid)
            nbeat++;
        if (fill_req.valid === 1'b1)
            fa = fill_req.addr;
    end
    task automatic chk(input string s, input logic [127:0] e, v);
        checked++;
        if (v !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", s, e, v);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n == 0 || (pready !== 1'b1 && n < 50); n++)
            @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // u selects the fetch port; the request stands until ack is sampled
    task automatic acc(input logic u, we, wt, input logic [31:0] ad, d);
        if (u)
            if_req <= '{1'b1, ad};
        else
            ls_req <= '{1'b1, we, wt, ad, d};
        for (n = 0; n == 0 || ((u ? if_rsp.ack : ls_rsp.ack) !== 1'b1 && n < 99); n++)
            @(posedge pclk);
        r = u ? if_rsp.rdata : ls_rsp.rdata;
        if_req <= '{1'b0, ~ad};
        ls_req <= '{1'b0, we, wt, ~ad, ~d};
        @(posedge pclk);
    endtask
    task automatic snp(input logic [31:0] ad);
        snoop <= '{1'b1, ad};
        @(posedge pclk);
        snoop <= '{1'b0, ~ad};
        @(posedge pclk);
        h = {snoop_retry, snoop_hit};
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reg", {i == 3, 32'h0}, {err, r});
        end
        acc(0, 0, 0, 32'h0001201C, 0);
        chk("critical word", 32'h0001201C, r);
        chk("fill address", 32'h00012018, fa);
        acc(0, 0, 0, 32'h00012004, 0);
        chk("refused in fill", 1, n > 2);
        chk("wrapped word", 32'h00012004, r);
        chk("beats", 4, nbeat);
        acc(0, 1, 0, 32'h00012008, 32'hC0FFEE01);
        chk("store hit", 2, n);
        chk("no write", 0, wq.size());
        fork
            snp(32'h00090000);
            acc(0, 0, 0, 32'h00012008, 0);
        join
        chk("snoop first", 0, h);
        chk("load next", 3, n);
        chk("modified", 32'hC0FFEE01, r);
        snp(32'h00012000);
        chk("snoop hit", 1, h);
        repeat (6) @(posedge pclk);
        chk("castouts", 4, wq.size());
        foreach (wq[k])
            chk("castout", {32'h00012000 + 32'(8 * k), BE_ALL, 32'h00012004 + 32'(8 * k),
                k == 1 ? 32'hC0FFEE01 : 32'h00012000 + 32'(8 * k)},
                {wq[k].addr, wq[k].be, wq[k].data});
        wq.delete();
        acc(0, 0, 0, 32'h00012008, 0);
        chk("invalid misses", 1, n > 2);
        repeat (4) @(posedge pclk);
        i = nbeat;
        acc(0, 1, 1, 32'h00034004, 32'h5A5A0001);
        @(posedge pclk);
        chk("write through", {1'b1, 32'h00034004, 64'h5A5A00015A5A0001, BE_HI}, wq[0]);
        chk("no allocate", i, nbeat);
        acc(1, 0, 0, 32'h00056010, 0);
        chk("fetch", 32'h00056010, r);
        repeat (10) @(posedge pclk);
        acc(1, 0, 0, 32'h00056014, 0);
        chk("fetch hit", 2, n);
        snp(32'h00056000);
        chk("no icache snoop", 0, h);
        acc(0, 1, 0, 32'h00056014, 32'h12345678);
        acc(1, 0, 0, 32'h00056014, 0);
        chk("icache kept", 32'h00056014, r);
        acc(0, 1, 1, 32'h00056010, 32'h0BADF00D);
        chk("wt hit", {1'b1, 32'h00056010, 64'h0BADF00D0BADF00D, BE_LO}, wq[$]);
        apb(1'b1, REG_CTRL, 32'h2);
        acc(1, 0, 0, 32'h00056014, 0);
        chk("flash invalidate", 1, n > 2);
        snp(32'h00056000);
        chk("snoop retry", 2, h);
        wrap_up;
    end
endmodule // testbench
`default_nettype wire

// ---- design/l1_pkg.sv ----
package l1_pkg;
    // organisation
    localparam int ADDR_W  = 32;
    localparam int SETS    = 128;
    localparam int WAYS    = 4;
    localparam int WAY_W   = 2;
    localparam int IDX_W   = 7;
    localparam int OFF_W   = 5;
    localparam int TAG_LSB = 12;
    localparam int TAG_W   = ADDR_W - TAG_LSB;
    localparam int DW_LSB  = 3;
    localparam int DW_W    = 2;
    localparam int WD_LSB  = 2;
    localparam int ENT_W   = IDX_W + WAY_W;
    localparam int ENTRIES = SETS * WAYS;
    localparam int DW_ENT  = ENTRIES * 4;
    localparam logic [DW_W-1:0] BEAT_LAST = 2'h3;
    localparam logic [7:0] BE_ALL = 8'hFF;
    localparam logic [7:0] BE_LO  = 8'h0F;
    localparam logic [7:0] BE_HI  = 8'hF0;
    // apb map
    localparam int PADDR_W = 8;
    localparam logic [PADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [PADDR_W-1:0] REG_SNOOPS = 8'h08;
    localparam int CTRL_DWT  = 0;
    localparam int CTRL_IINV = 1;

    typedef enum logic [1:0] {MEI_I = 2'h0, MEI_E = 2'h1, MEI_M = 2'h3} mei_t;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_CAST = 2'h1, ST_FILL = 2'h3} st_t;

    typedef struct packed {
        logic              valid;
        logic              we;
        logic              wt;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } ls_req_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } rsp_t;
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } areq_t;
    typedef struct packed {
        logic        valid;
        logic [63:0] data;
    } beat_t;
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [63:0]       data;
        logic [7:0]        be;
    } bus_wr_t;
endpackage

// ---- design/line_fill_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_fill_unit
    import l1_pkg::*;
(
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // start
    input  wire logic            start,
    input  wire logic [ADDR_W-1:0] addr,
    // bus side
    output areq_t                req,
    input  wire beat_t           beat,
    // array side
    output logic                 wr,
    output logic                 first,
    output logic                 done,
    output logic [DW_W-1:0]      pos
);
    logic            busy_q;
    logic [DW_W-1:0] cnt_q;
    logic [2:0]      nb_q;
    areq_t           req_q;

    assign req   = req_q;
    assign wr    = busy_q && beat.valid;
    assign first = wr && (cnt_q == '0);
    // [RULE11] four 64-bit beats
    assign done  = wr && (cnt_q == BEAT_LAST);
    // [RULE21] ascending, wraps in line
    assign pos   = req_q.addr[DW_LSB +: DW_W] + cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
            nb_q   <= '0;
            req_q  <= '0;
        end
        else if (start)
        begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
            nb_q   <= '0;
            // [RULE10] request address is the critical double word, 8-byte aligned, not the 8-word line base
            req_q  <= '{valid: 1'b1, addr: {addr[ADDR_W-1:DW_LSB], 3'h0}};
        end
        else if (wr)
        begin
            req_q.valid <= 1'b0;
            cnt_q       <= cnt_q + 2'h1;
            nb_q        <= nb_q + 3'h1;
            if (done)
                busy_q <= 1'b0;
        end
    end

    property p_crit_first;
        @(posedge pclk) disable iff (!presetn)
        start |=> req_q.valid && pos == $past(addr[DW_LSB +: DW_W]);
    endproperty
    a_crit_first: assert property (p_crit_first) else $error("first beat not critical"); // [RULE12]

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        wr && !done |=> !wr || (pos == DW_W'($past(pos) + 2'h1));
    endproperty
    a_wrap: assert property (p_wrap) else $error("beat order broken"); // [RULE21]

    property p_four;
        @(posedge pclk) disable iff (!presetn)
        done |-> nb_q == 3'h3 ##1 !busy_q;
    endproperty
    a_four: assert property (p_four) else $error("fill not four beats"); // [RULE11]
endmodule // line_fill_unit
`default_nettype wire

// ---- design/split_l1_cache.sv ----
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] separate 16 KB 4-way physical caches
// [RULE2] store policy from attribute: write-back/through
// [RULE3] data: 128 sets, 4 ways, 32B
// [RULE4] data state: modified, exclusive, invalid only
// [RULE5] line holds eight 32-bit words
// [RULE6] instr: 128x4, 32B, tag, valid
// [RULE7] instr data written only by fill
// [RULE8] instr cache ignores snoops
// [RULE9] one-cycle instr cache flash invalidate
// [RULE10] fill fetches aligned eight-word line; fill_req carries the critical double-word address, not the line base
// [RULE11] fill is four 64-bit beats
// [RULE12] critical double word comes first
// [RULE13] filling cache refuses accesses until done
// [RULE14] critical word stored and forwarded together
// [RULE15] modified line is sole valid copy
// [RULE16] exclusive line matches memory, unshared
// [RULE17] invalid line always misses
// [RULE18] snoops keep data cache coherent
// [RULE19] snoop wins data tag conflict
// [RULE20] losing access goes next cycle; after a snoop hit on a modified line it waits for the castout
// [RULE21] later beats ascend, wrap in line
module split_l1_cache
    import l1_pkg::*;
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // load/store and fetch units
    input  wire ls_req_t            ls_req,
    output rsp_t                    ls_rsp,
    input  wire areq_t              if_req,
    output rsp_t                    if_rsp,
    // snoop
    input  wire areq_t              snoop,
    output logic                    snoop_hit,
    output logic                    snoop_retry,
    // system bus
    output areq_t                   fill_req,
    input  wire beat_t              fill_beat,
    output bus_wr_t                 mem_wr
);
    st_t               st_q;
    logic              defer_q, ls_ack_q, if_ack_q, snp_hit_q, snp_rty_q;
    logic              pready_q, pslverr_q, dwt_q, cf_q, ti_q, fl_q, fwd_q;
    logic [31:0]       ls_rd_q, if_rd_q, prdata_q, snp_cnt_q;
    bus_wr_t           mem_wr_q;
    logic [WAY_W-1:0]  rr_q, cw_q, fw_q;
    logic [DW_W-1:0]   cc_q;
    logic [IDX_W-1:0]  cs_q, fs_q;
    logic [TAG_W-1:0]  ct_q, ft_q;
    logic [ADDR_W-1:0] fa_q;

    logic [TAG_W-1:0]  dtag [ENTRIES];
    logic [TAG_W-1:0]  itag [ENTRIES];
    mei_t              dst_q [ENTRIES];
    logic [ENTRIES-1:0] ival_q;
    logic [63:0]       dmem [DW_ENT];
    logic [63:0]       imem [DW_ENT];

    // single tag port: deferred access beats a new snoop
    wire               use_snp = snoop.valid && !defer_q;
    wire [ADDR_W-1:0]  da      = use_snp ? snoop.addr : ls_req.addr;
    wire [IDX_W-1:0]   d_set   = da[TAG_LSB-1:OFF_W];
    wire [TAG_W-1:0]   d_tag   = da[ADDR_W-1:TAG_LSB];
    wire [IDX_W-1:0]   i_set   = if_req.addr[TAG_LSB-1:OFF_W];
    wire [TAG_W-1:0]   i_tag   = if_req.addr[ADDR_W-1:TAG_LSB];

    logic [WAYS-1:0][TAG_W-1:0] d_tags, i_tags;
    logic [WAYS-1:0]            d_vld, i_vld;
    logic                       d_hit, i_hit;
    logic [WAY_W-1:0]           d_hw, d_vi, i_hw, i_vi;

    genvar w;
    generate
        for (w = 0; w < WAYS; w++)
        begin : g_ways
            // [RULE1] [RULE3] [RULE6] per-way tag read, set-indexed
            assign d_tags[w] = dtag[{d_set, WAY_W'(w)}];
            assign d_vld[w]  = dst_q[{d_set, WAY_W'(w)}] != MEI_I;
            assign i_tags[w] = itag[{i_set, WAY_W'(w)}];
            assign i_vld[w]  = ival_q[{i_set, WAY_W'(w)}];
        end
    endgenerate

    tag_match u_dtm (
        .way_tag (d_tags),
        .way_vld (d_vld),
        .tag     (d_tag),
        .rr      (rr_q),
        .hit     (d_hit),
        .hit_way (d_hw),
        .victim  (d_vi)
    );

    tag_match u_itm (
        .way_tag (i_tags),
        .way_vld (i_vld),
        .tag     (i_tag),
        .rr      (rr_q),
        .hit     (i_hit),
        .hit_way (i_hw),
        .victim  (i_vi)
    );

    wire              idle    = st_q == ST_IDLE;
    // [RULE18] snoop looks up data tags
    wire              snp_go  = idle && use_snp;
    // [RULE13] [RULE19] internal access only when idle and tags free
    wire              ls_go   = idle && ls_req.valid && !ls_ack_q && !use_snp;
    // [RULE8] fetch path never sees snoops
    wire              if_go   = idle && if_req.valid && !if_ack_q;
    wire              eff_wt  = ls_req.wt || dwt_q;
    wire [ENT_W-1:0]  d_he    = {d_set, d_hw};
    wire [ENT_W-1:0]  d_ve    = {d_set, d_vi};
    wire              ld_hit  = ls_go && d_hit && !ls_req.we;
    wire              st_hit  = ls_go && d_hit && ls_req.we;
    // [RULE2] write-through store miss does not allocate
    wire              wt_miss = ls_go && !d_hit && ls_req.we && eff_wt;
    wire              d_alloc = ls_go && !d_hit && !(ls_req.we && eff_wt);
    wire              vic_mod = dst_q[d_ve] == MEI_M;
    // [RULE15] modified hit must be pushed out
    wire              snp_mod = snp_go && d_hit && dst_q[d_he] == MEI_M;
    wire              if_fill = if_go && !i_hit && !snp_go && !ls_go;
    wire              cast_end = st_q == ST_CAST && cc_q == BEAT_LAST;
    wire              fill_go = (d_alloc && !vic_mod) || if_fill || (cast_end && cf_q);
    wire [ADDR_W-1:0] f_addr  = cast_end ? fa_q : (d_alloc ? ls_req.addr : if_req.addr);

    // [RULE5] word pick inside a double word, low word first
    wire [63:0]       d_line  = dmem[{d_he, ls_req.addr[DW_LSB +: DW_W]}];
    wire [31:0]       d_word  = ls_req.addr[WD_LSB] ? d_line[63:32] : d_line[31:0];
    wire [63:0]       i_line  = imem[{i_set, i_hw, if_req.addr[DW_LSB +: DW_W]}];
    wire [31:0]       i_word  = if_req.addr[WD_LSB] ? i_line[63:32] : i_line[31:0];
    wire [31:0]       fwd_w   = fwd_q ? fill_beat.data[63:32] : fill_beat.data[31:0];
    wire [63:0]       c_line  = dmem[{cs_q, cw_q, cc_q}];

    logic             fwr, ffirst, fdone;
    logic [DW_W-1:0]  fpos;

    line_fill_unit u_fill (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (fill_go),
        .addr    (f_addr),
        .req     (fill_req),
        .beat    (fill_beat),
        .wr      (fwr),
        .first   (ffirst),
        .done    (fdone),
        .pos     (fpos)
    );

    // [RULE7] only the fill writes instruction data
    wire              ic_wr   = fwr && ti_q;
    wire              dc_fwr  = fwr && !ti_q;

    // apb decode
    wire              apb_acc = psel && penable;
    wire              apb_wr  = apb_acc && pready_q && pwrite;
    wire              ctrl_wr = apb_wr && paddr == REG_CTRL;
    wire              ok_addr = paddr == REG_CTRL || paddr == REG_STATUS
                                || paddr == REG_SNOOPS;
    wire [31:0]       rd_mux  = paddr == REG_CTRL   ? {31'h0, dwt_q}
                              : paddr == REG_STATUS ? {30'h0, ti_q, !idle}
                              : paddr == REG_SNOOPS ? snp_cnt_q : 32'h0;
    // [RULE9] whole instruction cache dropped in one cycle
    wire              iinv    = ctrl_wr && pwdata[CTRL_IINV];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            dwt_q     <= 1'b0;
        end
        else
        begin
            // one wait state keeps read data a flop
            pready_q  <= apb_acc && !pready_q;
            pslverr_q <= apb_acc && !pready_q && !ok_addr;
            if (apb_acc && !pready_q)
                prdata_q <= rd_mux;
            if (ctrl_wr)
                dwt_q <= pwdata[CTRL_DWT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q      <= ST_IDLE;
            defer_q   <= 1'b0;
            ls_ack_q  <= 1'b0;
            if_ack_q  <= 1'b0;
            snp_hit_q <= 1'b0;
            snp_rty_q <= 1'b0;
            ls_rd_q   <= '0;
            if_rd_q   <= '0;
            snp_cnt_q <= '0;
            mem_wr_q  <= '0;
            rr_q      <= '0;
            cc_q      <= '0;
            cf_q      <= 1'b0;
            cs_q      <= '0;
            cw_q      <= '0;
            ct_q      <= '0;
            ti_q      <= 1'b0;
            fl_q      <= 1'b0;
            fwd_q     <= 1'b0;
            fs_q      <= '0;
            fw_q      <= '0;
            ft_q      <= '0;
            fa_q      <= '0;
        end
        else
        begin
            ls_ack_q       <= ld_hit || st_hit || wt_miss;
            if_ack_q       <= if_go && i_hit;
            snp_hit_q      <= snp_go && d_hit;
            // busy or slot taken: other master must retry
            snp_rty_q      <= snoop.valid && !snp_go;
            mem_wr_q.valid <= 1'b0;
            // [RULE20] loser gets the following cycle unless the snoop starts a castout
            defer_q        <= idle && use_snp && ls_req.valid && !ls_ack_q;
            if (snp_go && d_hit)
                snp_cnt_q <= snp_cnt_q + 32'h1;
            if (ld_hit)
                ls_rd_q <= d_word;
            if (if_go && i_hit)
                if_rd_q <= i_word;
            // [RULE2] write-through word goes to memory too
            if ((st_hit && eff_wt) || wt_miss)
                mem_wr_q <= '{valid: 1'b1, addr: {ls_req.addr[ADDR_W-1:WD_LSB], 2'h0},
                              data: {ls_req.wdata, ls_req.wdata},
                              be: ls_req.addr[WD_LSB] ? BE_HI : BE_LO};
            if (d_alloc || if_fill)
                rr_q <= rr_q + 2'h1;
            if (d_alloc)
            begin
                ti_q  <= 1'b0;
                fs_q  <= d_set;
                fw_q  <= d_vi;
                ft_q  <= d_tag;
                fl_q  <= !ls_req.we;
                fwd_q <= ls_req.addr[WD_LSB];
                fa_q  <= ls_req.addr;
            end
            else if (if_fill)
            begin
                ti_q  <= 1'b1;
                fs_q  <= i_set;
                fw_q  <= i_vi;
                ft_q  <= i_tag;
                fl_q  <= 1'b0;
                fwd_q <= if_req.addr[WD_LSB];
            end
            unique case (st_q)
                ST_IDLE:
                begin
                    cc_q <= '0;
                    if (snp_mod || (d_alloc && vic_mod))
                    begin
                        st_q <= ST_CAST;
                        cf_q <= !snp_mod;
                        cs_q <= d_set;
                        cw_q <= snp_mod ? d_hw : d_vi;
                        ct_q <= snp_mod ? d_tag : dtag[d_ve];
                    end
                    else if (fill_go)
                        st_q <= ST_FILL;
                end
                ST_CAST:
                begin
                    // [RULE15] castout of the only valid copy
                    mem_wr_q <= '{valid: 1'b1, addr: {ct_q, cs_q, cc_q, 3'h0},
                                  data: c_line, be: BE_ALL};
                    cc_q     <= cc_q + 2'h1;
                    if (cast_end)
                        st_q <= cf_q ? ST_FILL : ST_IDLE;
                end
                ST_FILL:
                begin
                    // [RULE14] forward while the beat is written
                    if (ffirst && ti_q)
                    begin
                        if_ack_q <= 1'b1;
                        if_rd_q  <= fwd_w;
                    end
                    else if (ffirst && fl_q)
                    begin
                        ls_ack_q <= 1'b1;
                        ls_rd_q  <= fwd_w;
                    end
                    if (fdone)
                        st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // line state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < ENTRIES; i++)
                dst_q[i] <= MEI_I;
            ival_q <= '0;
        end
        else
        begin
            // [RULE4] no shared state, snoop hit invalidates
            if (snp_go && d_hit)
                dst_q[d_he] <= MEI_I;
            if (st_hit && !eff_wt)
                dst_q[d_he] <= MEI_M;
            if (d_alloc)
                dst_q[d_ve] <= MEI_I;
            // [RULE16] fresh line equals memory
            if (fdone && !ti_q)
                dst_q[{fs_q, fw_q}] <= MEI_E;
            if (if_fill)
                ival_q[{i_set, i_vi}] <= 1'b0;
            if (fdone && ti_q)
                ival_q[{fs_q, fw_q}] <= 1'b1;
            // [RULE9] flush wins over a finishing fill
            if (iinv)
                ival_q <= '0;
        end
    end

    // arrays carry no reset; state bits guard them
    always_ff @(posedge pclk)
    begin
        if (fdone && !ti_q)
            dtag[{fs_q, fw_q}] <= ft_q;
        if (fdone && ti_q)
            itag[{fs_q, fw_q}] <= ft_q;
        if (dc_fwr)
            dmem[{fs_q, fw_q, fpos}] <= fill_beat.data;
        else if (st_hit && ls_req.addr[WD_LSB])
            dmem[{d_he, ls_req.addr[DW_LSB +: DW_W]}][63:32] <= ls_req.wdata;
        else if (st_hit)
            dmem[{d_he, ls_req.addr[DW_LSB +: DW_W]}][31:0] <= ls_req.wdata;
        if (ic_wr)
            imem[{fs_q, fw_q, fpos}] <= fill_beat.data;
    end

    assign pready      = pready_q;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q;
    assign ls_rsp      = '{ack: ls_ack_q, rdata: ls_rd_q};
    assign if_rsp      = '{ack: if_ack_q, rdata: if_rd_q};
    assign snoop_hit   = snp_hit_q;
    assign snoop_retry = snp_rty_q;
    assign mem_wr      = mem_wr_q;

    property p_snoop_first;
        @(posedge pclk) disable iff (!presetn)
        snoop.valid && !defer_q && ls_req.valid |-> !ls_go ##1 defer_q || !idle;
    endproperty
    a_snoop_first: assert property (p_snoop_first) else $error("snoop lost the tags"); // [RULE19]

    property p_ls_next;
        @(posedge pclk) disable iff (!presetn)
        defer_q && idle && ls_req.valid |-> ls_go;
    endproperty
    a_ls_next: assert property (p_ls_next) else $error("deferred access stalled"); // [RULE20]

    property p_block_fill;
        @(posedge pclk) disable iff (!presetn)
        st_q == ST_FILL |-> !ls_go && !if_go && !fill_go;
    endproperty
    a_block_fill: assert property (p_block_fill) else $error("access during fill"); // [RULE13]

    property p_fwd;
        @(posedge pclk) disable iff (!presetn)
        dc_fwr && ffirst && fl_q |=> ls_ack_q && ls_rd_q == $past(fwd_w);
    endproperty
    a_fwd: assert property (p_fwd) else $error("critical word not forwarded"); // [RULE14]

    property p_ic_nowrite;
        @(posedge pclk) disable iff (!presetn)
        ic_wr |-> st_q == ST_FILL && !st_hit;
    endproperty
    a_ic_nowrite: assert property (p_ic_nowrite) else $error("stray icache write"); // [RULE7]

    property p_mod_cast;
        @(posedge pclk) disable iff (!presetn)
        snp_mod |=> st_q == ST_CAST ##3 mem_wr_q.valid ##1 st_q == ST_IDLE;
    endproperty
    a_mod_cast: assert property (p_mod_cast) else $error("modified line not pushed"); // [RULE15]

    property p_wt_store;
        @(posedge pclk) disable iff (!presetn)
        st_hit && eff_wt |=> mem_wr_q.valid && mem_wr_q.data[31:0] == $past(ls_req.wdata);
    endproperty
    a_wt_store: assert property (p_wt_store) else $error("write-through lost"); // [RULE2]
endmodule // split_l1_cache
`default_nettype wire

// ---- design/tag_match.sv ----
`timescale 1ns/1ps
`default_nettype none
module tag_match
    import l1_pkg::*;
(
    // way tags and validity
    input  wire logic [WAYS-1:0][TAG_W-1:0] way_tag,
    input  wire logic [WAYS-1:0]            way_vld,
    input  wire logic [TAG_W-1:0]           tag,
    input  wire logic [WAY_W-1:0]           rr,
    // result
    output logic                            hit,
    output logic [WAY_W-1:0]                hit_way,
    output logic [WAY_W-1:0]                victim
);
    logic [WAYS-1:0] match;

    genvar g;
    generate
        for (g = 0; g < WAYS; g++)
        begin : g_way
            // [RULE17] invalid never matches
            assign match[g] = way_vld[g] && (way_tag[g] == tag);
        end
    endgenerate

    assign hit = |match;

    // invalid way preferred, else round robin
    always_comb
    begin
        hit_way = '0;
        victim  = rr;
        for (int i = WAYS - 1; i >= 0; i--)
        begin
            if (match[i])
                hit_way = WAY_W'(i);
            if (!way_vld[i])
                victim = WAY_W'(i);
        end
    end
endmodule // tag_match
`default_nettype wire
